// *** design/heater_pkg.sv ***
/*
 * constants shared by the heater controller: register map, field
 * positions, reset values and arithmetic scaling.
 * assumes a 32-bit ahb-lite fabric and signed 16-bit sensor words.
 */
package heater_pkg;
   // ****************************************
   // global register offsets
   // ****************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DIO_DIR = 8'h04;
   localparam logic [7:0] OFS_DIO_OUT = 8'h08;
   localparam logic [7:0] OFS_DIO_IN = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_MASK = 8'h14;
   localparam logic [7:0] OFS_LIM_LO = 8'h18;
   localparam logic [7:0] OFS_LIM_HI = 8'h1C;
   localparam logic [7:0] OFS_EXC0 = 8'h20;
   localparam logic [7:0] OFS_TEMP0 = 8'h30;
   // ****************************************
   // per-loop offsets, loop n at (n+1)*0x40
   // ****************************************
   localparam logic [5:0] LP_KP = 6'h00;
   localparam logic [5:0] LP_KI = 6'h04;
   localparam logic [5:0] LP_KD = 6'h08;
   localparam logic [5:0] LP_ILIM = 6'h0C;
   localparam logic [5:0] LP_TARGET = 6'h10;
   localparam logic [5:0] LP_PERIOD = 6'h14;
   localparam logic [5:0] LP_FIXED = 6'h18;
   localparam logic [5:0] LP_VMAX = 6'h1C;
   localparam logic [5:0] LP_SEL = 6'h20;
   localparam logic [5:0] LP_RATE = 6'h24;
   localparam logic [5:0] LP_DRIVE = 6'h28;
   localparam logic [5:0] LP_EFF = 6'h2C;
   // ****************************************
   // control and status fields
   // ****************************************
   localparam int CTRL_MODE0 = 0;
   localparam int CTRL_RAMP0 = 2;
   localparam int CTRL_SUPPLY = 4;
   localparam int CTRL_UPG = 5;
   localparam int ST_FAULT0 = 0;
   localparam int ST_UPD0 = 2;
   // ****************************************
   // reset values and scaling
   // ****************************************
   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam logic [3:0] DIO_DIR_RST = 4'h0;
   localparam logic [15:0] VMAX_RST = 16'h0000;
   localparam logic signed [15:0] LIM_LO_RST = 16'sh8000;
   localparam logic signed [15:0] LIM_HI_RST = 16'sh7FFF;
   localparam int PID_SHIFT = 8;
   localparam int EXC_STEP_NA = 25;
   localparam int EXC_MAX_NA = 1500000;
   localparam logic [15:0] EXC_MAX_CODE = 16'(EXC_MAX_NA / EXC_STEP_NA);
endpackage

// *** design/heater_pid_controller.sv ***
/*
 * two-channel heater controller: fixed or pid drive per output,
 * voltage clamp, sensor window cut-off, ramped target, dio setup,
 * ahb-lite register slave with sticky interrupt status.
 * assumes sensor words and dio inputs are synchronous to hclk.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - two heater loops with own settings; two sensors, three on upgraded card.
// - each output runs at fixed commanded voltage or under closed pid loop.
// - drive is clamped to the per-output maximum in both modes.
// - reading outside lower/upper bounds forces that output disabled.
// - each loop holds kp, ki, kd, integral limit and sensor select.
// - each loop evaluates once per its own programmable period.
// - error equals target minus selected sensor temperature.
// - proportional part is kp times current error.
// - error sum bounded by limit; integral part is ki times that sum.
// - derivative part is kd times error minus previous error.
// - parts summed and scaled linearly into drive, clamp still applied.
// - ramping starts target at measured temperature, moves at set rate.
// - eight dio lines, direction chosen per adjacent pair.
// - after reset all dio inputs, supply select external.
// - excitation current code in 25 nA steps up to 1.5 mA.
module heater_pid_controller
   import heater_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic irq,
   // sensors and heater drive
   input wire logic signed [15:0] sensor_temp [3],
   output logic [15:0] exc_code [3],
   output logic [15:0] heater_drive [2],
   output logic [1:0] heater_en,
   // digital io
   input wire logic [7:0] dio_in,
   output logic [7:0] dio_out,
   output logic [7:0] dio_oe,
   output logic digital_io_supply_select
);
   default clocking cb_hclk @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [15:0] clamp_v(input logic signed [42:0] v,
                                           input logic [15:0] vmax);
      if (v < 0)
         return 16'h0000;
      if (v > $signed({27'h0, vmax}))
         return vmax;
      return v[15:0];
   endfunction
   function automatic logic signed [15:0] step_to(input logic signed [15:0] cur,
         input logic signed [15:0] tgt, input logic [15:0] rate);
      logic signed [17:0] d;
      d = 18'(tgt) - 18'(cur);
      if (d > $signed({2'b00, rate}))
         return 16'(18'(cur) + $signed({2'b00, rate}));
      if (-d > $signed({2'b00, rate}))
         return 16'(18'(cur) - $signed({2'b00, rate}));
      return tgt;
   endfunction

   // ****************************************
   // ahb-lite slave
   // ****************************************
   logic ph_valid_r, ph_write_r;
   logic [7:0] ph_addr_r;
   logic wr_en;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wr_en = ph_valid_r & ph_write_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid_r <= 1'b0;
         ph_write_r <= 1'b0;
         ph_addr_r <= 8'h00;
      end else begin
         ph_valid_r <= hsel & hready & htrans[1];
         if (hsel & hready & htrans[1]) begin
            ph_write_r <= hwrite;
            ph_addr_r <= {haddr[7:2], 2'b00};
         end
      end
   end

   // ****************************************
   // configuration registers
   // ****************************************
   logic [5:0] ctrl_r;
   logic [3:0] dio_dir_r, status_r, mask_r, ev;
   logic [7:0] dio_out_r;
   logic signed [15:0] lim_lo_r, lim_hi_r;
   logic signed [15:0] kp_r [2], ki_r [2], kd_r [2], target_r [2];
   logic [23:0] ilim_r [2], period_r [2];
   logic [15:0] fixed_r [2], vmax_r [2], rate_r [2];
   logic [1:0] sel_r [2];
   logic [15:0] exc_r [3];
   logic [1:0] li;
   assign li = ph_addr_r[7:6];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= CTRL_RST;
         dio_dir_r <= DIO_DIR_RST;
         dio_out_r <= 8'h00;
         mask_r <= 4'h0;
         lim_lo_r <= LIM_LO_RST;
         lim_hi_r <= LIM_HI_RST;
         exc_r <= '{default: 16'h0000};
         for (int i = 0; i < 2; i++) begin
            kp_r[i] <= 16'sh0000;
            ki_r[i] <= 16'sh0000;
            kd_r[i] <= 16'sh0000;
            target_r[i] <= 16'sh0000;
            ilim_r[i] <= 24'h00_0000;
            period_r[i] <= 24'h00_0000;
            fixed_r[i] <= 16'h0000;
            vmax_r[i] <= VMAX_RST;
            rate_r[i] <= 16'h0000;
            sel_r[i] <= 2'b00;
         end
      end else if (wr_en) begin
         unique case (ph_addr_r)
            OFS_CTRL: ctrl_r <= hwdata[5:0];
            OFS_DIO_DIR: dio_dir_r <= hwdata[3:0];
            OFS_DIO_OUT: dio_out_r <= hwdata[7:0];
            OFS_MASK: mask_r <= hwdata[3:0];
            OFS_LIM_LO: lim_lo_r <= hwdata[15:0];
            OFS_LIM_HI: lim_hi_r <= hwdata[15:0];
            default: ;
         endcase
         for (int i = 0; i < 3; i++)
            if (ph_addr_r == OFS_EXC0 + 8'(4 * i))
               exc_r[i] <= (hwdata[15:0] > EXC_MAX_CODE) ? EXC_MAX_CODE : hwdata[15:0];
         if (li == 2'b01 || li == 2'b10) begin
            unique case (ph_addr_r[5:0])
               LP_KP: kp_r[li[1]] <= hwdata[15:0];
               LP_KI: ki_r[li[1]] <= hwdata[15:0];
               LP_KD: kd_r[li[1]] <= hwdata[15:0];
               LP_ILIM: ilim_r[li[1]] <= {1'b0, hwdata[22:0]};
               LP_TARGET: target_r[li[1]] <= hwdata[15:0];
               LP_PERIOD: period_r[li[1]] <= hwdata[23:0];
               LP_FIXED: fixed_r[li[1]] <= hwdata[15:0];
               LP_VMAX: vmax_r[li[1]] <= hwdata[15:0];
               LP_SEL: sel_r[li[1]] <= hwdata[1:0];
               LP_RATE: rate_r[li[1]] <= hwdata[15:0];
               default: ;
            endcase
         end
      end
   end

   // ****************************************
   // loop arithmetic
   // ****************************************
   logic signed [15:0] eff_r [2], temp_c [2];
   logic signed [16:0] err_c [2], err_prev_r [2];
   logic signed [24:0] acc_r [2], acc_c [2];
   logic signed [42:0] pid_c [2];
   logic [15:0] hold_r [2];
   logic [23:0] cnt_r [2];
   logic [1:0] ok, ok_d_r, tick, pid_on, ramp_on, ramp_d_r;

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         logic signed [25:0] s;
         s = 26'(acc_r[i]) + 26'(err_c[i]);
         pid_on[i] = ctrl_r[CTRL_MODE0 + i];
         ramp_on[i] = pid_on[i] & ctrl_r[CTRL_RAMP0 + i];
         // third sensor only on upgraded card
         temp_c[i] = sensor_temp[(sel_r[i] == 2'd3) ? 0 : sel_r[i]];
         ok[i] = (sel_r[i] < 2'd2 || (sel_r[i] == 2'd2 && ctrl_r[CTRL_UPG]))
                 && temp_c[i] >= lim_lo_r && temp_c[i] <= lim_hi_r;
         tick[i] = pid_on[i] && cnt_r[i] >= period_r[i];
         err_c[i] = 17'(eff_r[i]) - 17'(temp_c[i]);
         if (s > $signed({2'b00, ilim_r[i]}))
            acc_c[i] = $signed({1'b0, ilim_r[i]});
         else if (s < -$signed({2'b00, ilim_r[i]}))
            acc_c[i] = -$signed({1'b0, ilim_r[i]});
         else
            acc_c[i] = 25'(s);
         pid_c[i] = 43'(kp_r[i]) * 43'(err_c[i]) + 43'(ki_r[i]) * 43'(acc_c[i])
                    + 43'(kd_r[i]) * 43'(18'(err_c[i]) - 18'(err_prev_r[i]));
      end
   end
   // ****************************************
   // loop state and drive
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ok_d_r <= 2'b11;
         ramp_d_r <= 2'b00;
         heater_en <= 2'b00;
         for (int i = 0; i < 2; i++) begin
            eff_r[i] <= 16'sh0000;
            err_prev_r[i] <= 17'sh0_0000;
            acc_r[i] <= 25'sh000_0000;
            hold_r[i] <= 16'h0000;
            cnt_r[i] <= 24'h00_0000;
            heater_drive[i] <= 16'h0000;
         end
      end else begin
         ok_d_r <= ok;
         ramp_d_r <= ramp_on;
         for (int i = 0; i < 2; i++) begin
            cnt_r[i] <= (tick[i] || !pid_on[i]) ? 24'h00_0000 : cnt_r[i] + 24'h00_0001;
            if (!ramp_on[i])
               eff_r[i] <= target_r[i];
            else if (!ramp_d_r[i])
               eff_r[i] <= temp_c[i];
            else if (tick[i])
               eff_r[i] <= step_to(eff_r[i], target_r[i], rate_r[i]);
            if (!ok[i] || !pid_on[i]) begin
               acc_r[i] <= 25'sh000_0000;
               err_prev_r[i] <= 17'sh0_0000;
               hold_r[i] <= 16'h0000;
            end else if (tick[i]) begin
               acc_r[i] <= acc_c[i];
               err_prev_r[i] <= err_c[i];
               hold_r[i] <= clamp_v(pid_c[i] >>> PID_SHIFT, 16'hFFFF);
            end
            heater_en[i] <= ok[i];
            if (!ok[i])
               heater_drive[i] <= 16'h0000;
            else if (pid_on[i])
               heater_drive[i] <= clamp_v(43'({1'b0, hold_r[i]}), vmax_r[i]);
            else
               heater_drive[i] <= clamp_v(43'({1'b0, fixed_r[i]}), vmax_r[i]);
         end
      end
   end

   // ****************************************
   // status, interrupt, dio
   // ****************************************
   assign ev = {tick & ok, ok_d_r & ~ok};
   assign irq = |(status_r & mask_r);
   assign exc_code = exc_r;
   assign dio_out = dio_out_r;
   assign digital_io_supply_select = ctrl_r[CTRL_SUPPLY];
   assign dio_oe = {{2{dio_dir_r[3]}}, {2{dio_dir_r[2]}}, {2{dio_dir_r[1]}},
                    {2{dio_dir_r[0]}}};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         status_r <= 4'h0;
      else if (wr_en && ph_addr_r == OFS_STATUS)
         status_r <= (status_r & ~hwdata[3:0]) | ev;
      else
         status_r <= status_r | ev;
   end

   always_comb begin
      hrdata = 32'h0000_0000;
      if (ph_valid_r && !ph_write_r) begin
         unique case (ph_addr_r)
            OFS_CTRL: hrdata = {26'h0, ctrl_r};
            OFS_DIO_DIR: hrdata = {28'h0, dio_dir_r};
            OFS_DIO_OUT: hrdata = {24'h0, dio_out_r};
            OFS_DIO_IN: hrdata = {24'h0, dio_in};
            OFS_STATUS: hrdata = {28'h0, status_r};
            OFS_MASK: hrdata = {28'h0, mask_r};
            OFS_LIM_LO: hrdata = {16'h0, lim_lo_r};
            OFS_LIM_HI: hrdata = {16'h0, lim_hi_r};
            default: ;
         endcase
         for (int i = 0; i < 3; i++) begin
            if (ph_addr_r == OFS_EXC0 + 8'(4 * i))
               hrdata = {16'h0, exc_r[i]};
            if (ph_addr_r == OFS_TEMP0 + 8'(4 * i))
               hrdata = {16'h0, sensor_temp[i]};
         end
         if (li == 2'b01 || li == 2'b10) begin
            unique case (ph_addr_r[5:0])
               LP_KP: hrdata = {16'h0, kp_r[li[1]]};
               LP_KI: hrdata = {16'h0, ki_r[li[1]]};
               LP_KD: hrdata = {16'h0, kd_r[li[1]]};
               LP_ILIM: hrdata = {8'h0, ilim_r[li[1]]};
               LP_TARGET: hrdata = {16'h0, target_r[li[1]]};
               LP_PERIOD: hrdata = {8'h0, period_r[li[1]]};
               LP_FIXED: hrdata = {16'h0, fixed_r[li[1]]};
               LP_VMAX: hrdata = {16'h0, vmax_r[li[1]]};
               LP_SEL: hrdata = {30'h0, sel_r[li[1]]};
               LP_RATE: hrdata = {16'h0, rate_r[li[1]]};
               LP_DRIVE: hrdata = {16'h0, heater_drive[li[1]]};
               LP_EFF: hrdata = {16'h0, eff_r[li[1]]};
               default: ;
            endcase
         end
      end
   end
   // ****************************************
   // assertions
   // ****************************************
   property p_clamp;
      1'b1 |=> heater_drive[0] <= $past(vmax_r[0]);
   endproperty
   a_clamp: assert property (p_clamp) else $error("drive above max");
   property p_cutoff;
      !ok[1] |=> heater_drive[1] == 16'h0000 && !heater_en[1];
   endproperty
   a_cutoff: assert property (p_cutoff) else $error("drive not cut");
   property p_fixed;
      !pid_on[0] && ok[0] && fixed_r[0] <= vmax_r[0] |=> heater_drive[0] == $past(fixed_r[0]);
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed drive wrong");
   property p_bound;
      tick[0] && ok[0] |=> acc_r[0] <= $signed({1'b0, $past(ilim_r[0])})
                           && acc_r[0] >= -$signed({1'b0, $past(ilim_r[0])});
   endproperty
   a_bound: assert property (p_bound) else $error("sum out of bound");
   property p_spacing;
      tick[0] && period_r[0] == 24'h00_0003 && $stable(period_r[0]) |=> !tick[0] [*3];
   endproperty
   a_spacing: assert property (p_spacing) else $error("tick too soon");
   property p_prev;
      tick[0] && ok[0] |=> err_prev_r[0] == $past(err_c[0]);
   endproperty
   a_prev: assert property (p_prev) else $error("previous error lost");
   property p_ramp_start;
      $rose(ramp_on[0]) |=> eff_r[0] == $past(temp_c[0]);
   endproperty
   a_ramp_start: assert property (p_ramp_start) else $error("ramp start wrong");
   property p_pairs;
      (dio_oe & 8'h55) == ((dio_oe >> 1) & 8'h55);
   endproperty
   a_pairs: assert property (p_pairs) else $error("pair split");
   property p_sticky;
      ok_d_r[0] && !ok[0] |=> status_r[ST_FAULT0];
   endproperty
   a_sticky: assert property (p_sticky) else $error("fault not flagged");
   c_tick: cover property (tick[0] && ok[0]);
   c_fault: cover property ($fell(ok[1]));
   c_ramp: cover property (ramp_d_r[0] && tick[0] && eff_r[0] != target_r[0]);
   c_irq: cover property ($rose(irq));
endmodule

// *** testbench/sensor_plant.sv ***
/*
 * sensor front-end model: three temperature adc channels facing the
 * heater controller. assumes the bench sets the physical temperature.
 */
`timescale 1ns/1ps
module sensor_plant #(
   parameter int LAG = 2
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // physical temperatures
   input wire logic signed [15:0] phys_temp [3],
   // converted words
   output logic signed [15:0] sensor_temp [3]
);
   logic signed [15:0] pipe_r [LAG][3];

   // ****************************************
   // conversion delay
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int k = 0; k < LAG; k++) begin
            pipe_r[k] <= '{default: 16'sh0000};
         end
      end else begin
         pipe_r[0] <= phys_temp;
         for (int k = 1; k < LAG; k++) begin
            pipe_r[k] <= pipe_r[k-1];
         end
      end
   end
   assign sensor_temp = pipe_r[LAG-1];
endmodule

// *** testbench/tb_heater_pid_controller.sv ***
/*
 * self-checking bench for the heater controller over ahb-lite.
 * assumes the sensor model and the controller share hclk.
 */
`timescale 1ns/1ps
module tb_heater_pid_controller
   import heater_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, sup;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0] htrans, en;
   logic signed [15:0] phys [3];
   logic signed [15:0] sens [3];
   logic [15:0] exc [3];
   logic [15:0] drv [2];
   logic [7:0] dio_in, dio_out, dio_oe;
   int err_total, checks;

   // ****************************************
   // clock, reset, instances
   // ****************************************
   initial begin
      hclk = 0;
      forever #20 hclk = ~hclk;
   end

   sensor_plant i_plant (.hclk(hclk), .hresetn(hresetn), .phys_temp(phys), .sensor_temp(sens));
   heater_pid_controller i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
      .sensor_temp(sens), .exc_code(exc), .heater_drive(drv), .heater_en(en),
      .dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe), .digital_io_supply_select(sup));

   // ****************************************
   // helpers
   // ****************************************
   task automatic end_of_test();
      $display("errors %0d checks %0d", err_total, checks);
      if (err_total == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      v = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0000_0000);
      chk(v, exp);
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge hclk);
   endtask

   function automatic logic [7:0] lpa(input int n, input logic [5:0] o);
      return 8'(8'h40 * (n + 1)) + {2'b00, o};
   endfunction

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      rchk(OFS_CTRL, 32'h0000_0000);
      rchk(OFS_DIO_DIR, 32'h0000_0000);
      chk({24'h0, dio_oe}, 32'h0000_0000);
      chk({31'h0, sup}, 32'h0000_0000);
      chk({31'h0, hresp}, 32'h0000_0000);
      rchk(OFS_LIM_LO, 32'h0000_8000);
      rchk(OFS_LIM_HI, 32'h0000_7FFF);
      rchk(lpa(0, LP_VMAX), 32'h0000_0000);
      rchk(8'hFC, 32'h0000_0000);
   endtask

   task automatic t_dio();
      wr(OFS_DIO_DIR, 32'h0000_0005);
      wr(OFS_DIO_OUT, 32'h0000_00A5);
      wt(2);
      chk({24'h0, dio_oe}, 32'h0000_0033);
      chk({24'h0, dio_out}, 32'h0000_00A5);
      dio_in <= 8'h3C;
      rchk(OFS_DIO_IN, 32'h0000_003C);
      wr(OFS_CTRL, 32'h0000_0010);
      wt(2);
      chk({31'h0, sup}, 32'h0000_0001);
      wr(OFS_CTRL, 32'h0000_0000);
   endtask

   task automatic t_exc();
      wr(OFS_EXC0, 32'h0000_FFFF);
      wr(OFS_EXC0 + 8'h08, 32'h0000_0064);
      wt(2);
      chk({16'h0, exc[0]}, {16'h0, EXC_MAX_CODE});
      chk({16'h0, exc[2]}, 32'h0000_0064);
   endtask

   task automatic t_fixed();
      wr(lpa(1, LP_FIXED), 32'h0000_0777);
      wr(lpa(1, LP_VMAX), 32'h0000_FFFF);
      wr(lpa(0, LP_FIXED), 32'h0000_1234);
      wr(lpa(0, LP_VMAX), 32'h0000_1000);
      wt(3);
      chk({16'h0, drv[1]}, 32'h0000_0777);
      chk({30'h0, en}, 32'h0000_0003);
      chk({16'h0, drv[0]}, 32'h0000_1000);
      wr(lpa(1, LP_VMAX), 32'h0000_0500);
      wt(3);
      chk({16'h0, drv[1]}, 32'h0000_0500);
   endtask

   task automatic t_sel();
      wr(lpa(1, LP_SEL), 32'h0000_0002);
      wt(4);
      chk({31'h0, en[1]}, 32'h0000_0000);
      wr(OFS_CTRL, 32'h0000_0020);
      wt(4);
      chk({31'h0, en[1]}, 32'h0000_0001);
   endtask

   task automatic t_pid();
      phys[1] <= 16'sd80;
      wr(lpa(0, LP_VMAX), 32'h0000_FFFF);
      wr(lpa(0, LP_KP), 32'h0000_0100);
      wr(lpa(0, LP_TARGET), 32'h0000_0064);
      // short period suits the two-cycle sensor lag
      wr(lpa(0, LP_PERIOD), 32'h0000_0003);
      wr(lpa(0, LP_SEL), 32'h0000_0001);
      wr(OFS_CTRL, 32'h0000_0021);
      wt(30);
      chk({16'h0, drv[0]}, 32'h0000_0014);
      phys[1] <= 16'sd150;
      wt(30);
      chk({16'h0, drv[0]}, 32'h0000_0000);
      wr(lpa(0, LP_KP), 32'h0000_0000);
      wr(lpa(0, LP_KI), 32'h0000_0100);
      wr(lpa(0, LP_ILIM), 32'h0000_0014);
      phys[1] <= 16'sd50;
      wt(30);
      chk({16'h0, drv[0]}, 32'h0000_0014);
      wr(lpa(0, LP_KD), 32'h0000_0100);
      wt(30);
      chk({16'h0, drv[0]}, 32'h0000_0014);
      wr(lpa(0, LP_VMAX), 32'h0000_000A);
      wt(10);
      chk({16'h0, drv[0]}, 32'h0000_000A);
      rchk(lpa(0, LP_DRIVE), 32'h0000_000A);
      xfer(OFS_STATUS, 1'b0, 32'h0000_0000);
      chk({31'h0, v[ST_UPD0]}, 32'h0000_0001);
   endtask

   task automatic t_window();
      wr(OFS_LIM_HI, 32'h0000_00C8);
      phys[1] <= 16'sd300;
      wt(10);
      chk({30'h0, en[0], drv[0] == 16'h0000}, 32'h0000_0001);
      rchk(OFS_TEMP0 + 8'h04, 32'h0000_012C);
      xfer(OFS_STATUS, 1'b0, 32'h0000_0000);
      chk({31'h0, v[ST_FAULT0]}, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(OFS_MASK, 32'h0000_0001);
      wt(2);
      chk({31'h0, irq}, 32'h0000_0001);
      phys[1] <= 16'sd50;
      wr(OFS_STATUS, 32'h0000_0001);
      wt(2);
      chk({31'h0, irq}, 32'h0000_0000);
      chk({31'h0, en[0]}, 32'h0000_0001);
   endtask

   task automatic t_ramp();
      wr(lpa(0, LP_PERIOD), 32'h0000_00C8);
      wr(lpa(0, LP_TARGET), 32'h0000_003C);
      wr(lpa(0, LP_RATE), 32'h0000_0004);
      wr(OFS_CTRL, 32'h0000_0025);
      rchk(lpa(0, LP_EFF), 32'h0000_0032);
      wt(900);
      rchk(lpa(0, LP_EFF), 32'h0000_003C);
   endtask

   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      err_total = 0;
      checks = 0;
      hresetn = 0;
      hsel = 0;
      haddr = 0;
      htrans = 0;
      hwrite = 0;
      hwdata = 0;
      dio_in = 8'h00;
      phys = '{16'sd50, 16'sd50, 16'sd50};
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_dio();
      t_exc();
      t_fixed();
      t_sel();
      t_pid();
      t_window();
      t_ramp();
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge hclk);
      err_total++;
      end_of_test();
   end
endmodule
